/* awc_regs.svh */
// Constants for the analog word calculators
`ifndef AWC_REGS_SVH
`define AWC_REGS_SVH

// ----------------------------------------
// Word widths and field positions
// ----------------------------------------
`define AWC_WORD_W 16
`define AWC_OP_W 2
`define AWC_OP1_LSB 0
`define AWC_OP2_LSB 2
`define AWC_OP3_LSB 4

// ----------------------------------------
// Reset and limit values, and the double word mode code
// ----------------------------------------
`define AWC_OUT_RST 16'h0000
`define AWC_OUT_MAX 16'hFFFF
`define AWC_C1_PAR_MIN 16'h8002
`define AWC_MODE_DWORD 2'h2
`define AWC_INT_LIM 64'h0000_0000_8000_0000

`endif

/* awc_pkg.sv */
// Types and shared arithmetic helpers for the analog word calculators
`include "awc_regs.svh"

package awc_pkg;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {AWC_OP_ADD, AWC_OP_SUB, AWC_OP_MUL, AWC_OP_DIV} awc_op_t;
   typedef enum logic [1:0] {AWC_PRIO_HIGH, AWC_PRIO_MED, AWC_PRIO_LOW, AWC_PRIO_LOW2} awc_prio_t;
   typedef logic signed [63:0] awc_wide_t;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Clip to unsigned 16-bit range
   function automatic logic [15:0] sat16(input awc_wide_t v);
      logic [15:0] r;
      r = v[15:0];
      if (v < 64'sh0000_0000_0000_0000) begin
         r = `AWC_OUT_RST;
      end else if (v > 64'sh0000_0000_0000_FFFF) begin
         r = `AWC_OUT_MAX;
      end
      return r;
   endfunction : sat16

   // Keep intermediates small enough that a product cannot wrap
   function automatic awc_wide_t clampw(input awc_wide_t v);
      awc_wide_t r;
      r = v;
      if (v > $signed(`AWC_INT_LIM)) begin
         r = $signed(`AWC_INT_LIM);
      end else if (v < -$signed(`AWC_INT_LIM)) begin
         r = -$signed(`AWC_INT_LIM);
      end
      return r;
   endfunction : clampw

   function automatic awc_wide_t op_apply(input awc_wide_t a, input awc_wide_t b, input awc_op_t op);
      awc_wide_t r;
      r = a + b;
      case (op)
         AWC_OP_ADD: r = a + b;
         AWC_OP_SUB: r = a - b;
         AWC_OP_MUL: r = a * b;
         AWC_OP_DIV: r = (b == 64'sh0000_0000_0000_0000) ? a : a / b;
         default: r = a + b;
      endcase
      return clampw(r);
   endfunction : op_apply

   function automatic logic div_zero(input awc_wide_t b, input awc_op_t op);
      return (op == AWC_OP_DIV) && (b == 64'sh0000_0000_0000_0000);
   endfunction : div_zero

   // Rank 0 evaluates first
   function automatic logic [1:0] prio_rank(input awc_prio_t p);
      logic [1:0] r;
      r = 2'h2;
      if (p == AWC_PRIO_HIGH) begin
         r = 2'h0;
      end else if (p == AWC_PRIO_MED) begin
         r = 2'h1;
      end
      return r;
   endfunction : prio_rank

endpackage : awc_pkg

/* awc_chain.sv */
// Four-input operator chain with priority ordering and fixed-level inputs
`timescale 1ns/1ns
`include "awc_regs.svh"

module awc_chain (
   // Analog inputs, word 0 is input 1
   input wire logic [63:0] in_vec_i,
   input wire logic [3:0] fix_i,
   input wire logic [63:0] const_vec_i,
   // Operators and priorities
   input wire logic [5:0] op_vec_i,
   input wire logic [1:0] prio1_i,
   input wire logic [1:0] prio2_i,
   // Result
   output logic [15:0] res_o
);

   awc_pkg::awc_wide_t opnd [4];
   awc_pkg::awc_op_t op1;
   awc_pkg::awc_op_t op2;
   awc_pkg::awc_op_t op3;
   logic [1:0] rank1;
   logic [1:0] rank2;
   logic left_first;
   awc_pkg::awc_wide_t lf_ab;
   awc_pkg::awc_wide_t lf_abc;
   awc_pkg::awc_wide_t rf_bc;
   awc_pkg::awc_wide_t rf_abc;
   awc_pkg::awc_wide_t abc;
   awc_pkg::awc_wide_t total;
   logic dz_left;
   logic dz_right;
   logic div0;

   // ----------------------------------------
   // Operand selection
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_opnd
         assign opnd[g] = fix_i[g] ? $signed({48'h0000_0000_0000, const_vec_i[g*16 +: 16]})
                                   : $signed({48'h0000_0000_0000, in_vec_i[g*16 +: 16]});
      end
   endgenerate

   assign op1 = awc_pkg::awc_op_t'(op_vec_i[`AWC_OP1_LSB +: `AWC_OP_W]);
   assign op2 = awc_pkg::awc_op_t'(op_vec_i[`AWC_OP2_LSB +: `AWC_OP_W]);
   assign op3 = awc_pkg::awc_op_t'(op_vec_i[`AWC_OP3_LSB +: `AWC_OP_W]);

   // ----------------------------------------
   // Evaluation order
   // ----------------------------------------
   // Operator 2 never ranks high; operator 3 is always last
   assign rank1 = awc_pkg::prio_rank(awc_pkg::awc_prio_t'(prio1_i));
   assign rank2 = (awc_pkg::prio_rank(awc_pkg::awc_prio_t'(prio2_i)) == 2'h0) ? 2'h1
                : awc_pkg::prio_rank(awc_pkg::awc_prio_t'(prio2_i));
   // Ties fall back to left to right
   assign left_first = (rank1 <= rank2);

   assign lf_ab = awc_pkg::op_apply(opnd[0], opnd[1], op1);
   assign lf_abc = awc_pkg::op_apply(lf_ab, opnd[2], op2);
   assign rf_bc = awc_pkg::op_apply(opnd[1], opnd[2], op2);
   assign rf_abc = awc_pkg::op_apply(opnd[0], rf_bc, op1);
   assign abc = left_first ? lf_abc : rf_abc;
   assign total = awc_pkg::op_apply(abc, opnd[3], op3);

   assign dz_left = awc_pkg::div_zero(opnd[1], op1) | awc_pkg::div_zero(opnd[2], op2);
   assign dz_right = awc_pkg::div_zero(opnd[2], op2) | awc_pkg::div_zero(rf_bc, op1);
   assign div0 = (left_first ? dz_left : dz_right) | awc_pkg::div_zero(opnd[3], op3);

   assign res_o = div0 ? `AWC_OUT_MAX : awc_pkg::sat16(total);

endmodule : awc_chain

/* awc_top.sv */
// Analog word calculators 1 to 4 with registered outputs
`timescale 1ns/1ns
`include "awc_regs.svh"

module awc_top (
   // Clock and reset
   input wire logic MCLK_I,
   input wire logic RST_B_I,
   // Calculator 1
   input wire logic [15:0] C1_IN_I,
   input wire logic [15:0] C1_NUM_I,
   input wire logic [7:0] C1_DEN_I,
   input wire logic [15:0] C1_OFS_I,
   // Calculator 2
   input wire logic [15:0] C2_IN1_I,
   input wire logic [15:0] C2_IN2_I,
   input wire logic [7:0] C2_NUM1_I,
   input wire logic [7:0] C2_DEN1_I,
   input wire logic [7:0] C2_NUM2_I,
   input wire logic [7:0] C2_DEN2_I,
   input wire logic [31:0] C2_OFS_I,
   input wire logic [1:0] C2_MODE_I,
   input wire logic [1:0] C2_OP_I,
   // Calculator 3
   input wire logic [63:0] C3_IN_I,
   input wire logic [3:0] C3_FIX_I,
   input wire logic [63:0] C3_CONST_I,
   input wire logic [5:0] C3_OP_I,
   input wire logic [1:0] C3_PRIO1_I,
   input wire logic [1:0] C3_PRIO2_I,
   // Calculator 4
   input wire logic [63:0] C4_IN_I,
   input wire logic [3:0] C4_FIX_I,
   input wire logic [63:0] C4_CONST_I,
   input wire logic [5:0] C4_OP_I,
   input wire logic [1:0] C4_PRIO1_I,
   input wire logic [1:0] C4_PRIO2_I,
   // Results
   output logic [15:0] C1_OUT_O,
   output logic [15:0] C2_OUT_O,
   output logic [15:0] C3_OUT_O,
   output logic [15:0] C4_OUT_O
);

   // ----------------------------------------
   // Calculator 1
   // ----------------------------------------
   logic [15:0] c1_num_cl;
   logic [15:0] c1_ofs_cl;
   awc_pkg::awc_wide_t c1_prod;
   awc_pkg::awc_wide_t c1_quot;
   awc_pkg::awc_wide_t c1_sum;
   logic [15:0] c1_nxt;
   logic [15:0] c1_r;

   // Two lowest codes lie below the legal range
   assign c1_num_cl = ($signed(C1_NUM_I) < $signed(`AWC_C1_PAR_MIN)) ? `AWC_C1_PAR_MIN : C1_NUM_I;
   assign c1_ofs_cl = ($signed(C1_OFS_I) < $signed(`AWC_C1_PAR_MIN)) ? `AWC_C1_PAR_MIN : C1_OFS_I;
   assign c1_prod = $signed({48'h0000_0000_0000, C1_IN_I}) * $signed({{48{c1_num_cl[15]}}, c1_num_cl});
   assign c1_quot = (C1_DEN_I == 8'h00) ? c1_prod
                  : c1_prod / $signed({56'h0000_0000_0000_00, C1_DEN_I});
   assign c1_sum = c1_quot + $signed({{48{c1_ofs_cl[15]}}, c1_ofs_cl});
   assign c1_nxt = (C1_DEN_I == 8'h00) ? `AWC_OUT_MAX : awc_pkg::sat16(c1_sum);

   // ----------------------------------------
   // Calculator 2
   // ----------------------------------------
   awc_pkg::awc_wide_t c2_ofs;
   awc_pkg::awc_wide_t c2_t1;
   awc_pkg::awc_wide_t c2_t2;
   awc_pkg::awc_wide_t c2_m1;
   awc_pkg::awc_wide_t c2_dw;
   awc_pkg::awc_wide_t c2_m2;
   awc_pkg::awc_wide_t c2_num1;
   awc_pkg::awc_wide_t c2_den1;
   awc_pkg::awc_wide_t c2_den2;
   awc_pkg::awc_op_t c2_op;
   logic c2_mode2;
   logic c2_dz1;
   logic c2_dz_m1;
   logic [15:0] c2_nxt;
   logic [15:0] c2_r;

   assign c2_mode2 = (C2_MODE_I == `AWC_MODE_DWORD);
   assign c2_op = awc_pkg::awc_op_t'(C2_OP_I);
   assign c2_ofs = $signed({{32{C2_OFS_I[31]}}, C2_OFS_I});
   assign c2_num1 = $signed({{56{C2_NUM1_I[7]}}, C2_NUM1_I});
   assign c2_den1 = $signed({56'h0000_0000_0000_00, C2_DEN1_I});
   assign c2_den2 = $signed({{56{C2_DEN2_I[7]}}, C2_DEN2_I});
   assign c2_dz1 = (C2_DEN1_I == 8'h00);

   // Mode 1: scaled input 1 combined with scaled input 2
   assign c2_t1 = c2_dz1 ? 64'sh0000_0000_0000_0000
                : ($signed({48'h0000_0000_0000, C2_IN1_I}) * c2_num1) / c2_den1;
   assign c2_t2 = (C2_DEN2_I == 8'h00) ? 64'sh0000_0000_0000_0000
                : ($signed({48'h0000_0000_0000, C2_IN2_I}) * $signed({56'h0000_0000_0000_00, C2_NUM2_I}))
                  / c2_den2;
   assign c2_m1 = awc_pkg::op_apply(c2_t1, c2_t2, c2_op) + c2_ofs;
   assign c2_dz_m1 = c2_dz1 | (C2_DEN2_I == 8'h00) | awc_pkg::div_zero(c2_t2, c2_op);

   // Mode 2: double word, input 1 high
   assign c2_dw = $signed({32'h0000_0000, C2_IN1_I, C2_IN2_I});
   assign c2_m2 = c2_dz1 ? 64'sh0000_0000_0000_0000 : (c2_dw * c2_num1) / c2_den1 + c2_ofs;

   // Mode 2 never looks at numerator 2, denominator 2 or the operator
   assign c2_nxt = c2_mode2 ? (c2_dz1 ? `AWC_OUT_MAX : awc_pkg::sat16(c2_m2))
                 : (c2_dz_m1 ? `AWC_OUT_MAX : awc_pkg::sat16(c2_m1));

   // ----------------------------------------
   // Calculators 3 and 4
   // ----------------------------------------
   logic [63:0] ch_in [2];
   logic [3:0] ch_fix [2];
   logic [63:0] ch_const [2];
   logic [5:0] ch_op [2];
   logic [1:0] ch_p1 [2];
   logic [1:0] ch_p2 [2];
   logic [15:0] ch_nxt [2];
   logic [15:0] ch_r [2];

   assign ch_in[0] = C3_IN_I;
   assign ch_in[1] = C4_IN_I;
   assign ch_fix[0] = C3_FIX_I;
   assign ch_fix[1] = C4_FIX_I;
   assign ch_const[0] = C3_CONST_I;
   assign ch_const[1] = C4_CONST_I;
   assign ch_op[0] = C3_OP_I;
   assign ch_op[1] = C4_OP_I;
   assign ch_p1[0] = C3_PRIO1_I;
   assign ch_p1[1] = C4_PRIO1_I;
   assign ch_p2[0] = C3_PRIO2_I;
   assign ch_p2[1] = C4_PRIO2_I;

   genvar k;
   generate
      for (k = 0; k < 2; k++) begin : g_chain
         awc_chain u_chain (
            .in_vec_i(ch_in[k]),
            .fix_i(ch_fix[k]),
            .const_vec_i(ch_const[k]),
            .op_vec_i(ch_op[k]),
            .prio1_i(ch_p1[k]),
            .prio2_i(ch_p2[k]),
            .res_o(ch_nxt[k])
         );

         always_ff @(posedge MCLK_I or negedge RST_B_I) begin
            if (!RST_B_I) begin
               ch_r[k] <= `AWC_OUT_RST;
            end else begin
               ch_r[k] <= ch_nxt[k];
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Output registers
   // ----------------------------------------
   always_ff @(posedge MCLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         c1_r <= `AWC_OUT_RST;
         c2_r <= `AWC_OUT_RST;
      end else begin
         c1_r <= c1_nxt;
         c2_r <= c2_nxt;
      end
   end

   assign C1_OUT_O = c1_r;
   assign C2_OUT_O = c2_r;
   assign C3_OUT_O = ch_r[0];
   assign C4_OUT_O = ch_r[1];

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge MCLK_I);
   endclocking
   default disable iff (!RST_B_I);

   property p_c1_unity;
      (C1_NUM_I == 16'h0001) && (C1_DEN_I == 8'h01) && (C1_OFS_I == 16'h0000) |=> C1_OUT_O == $past(C1_IN_I);
   endproperty
   a_c1_unity: assert property (p_c1_unity) else $error("calc1 unity scaling wrong");

   property p_c1_num_floor;
      $signed(c1_num_cl) >= -32766 && $signed(c1_ofs_cl) >= -32766;
   endproperty
   a_c1_num_floor: assert property (p_c1_num_floor) else $error("calc1 parameter below range");

   property p_c1_div0;
      (C1_DEN_I == 8'h00) |=> C1_OUT_O == 16'hFFFF;
   endproperty
   a_c1_div0: assert property (p_c1_div0) else $error("calc1 divide by zero not 65535");

   property p_c1_neg_sat;
      (C1_NUM_I == 16'hFFFF) && (C1_DEN_I == 8'h01) && (C1_OFS_I == 16'h0000) && (C1_IN_I != 16'h0000)
      |=> C1_OUT_O == 16'h0000;
   endproperty
   a_c1_neg_sat: assert property (p_c1_neg_sat) else $error("calc1 negative result not clipped");

   property p_c2_mode1_add;
      (C2_MODE_I == 2'h1) && (C2_OP_I == 2'h0) && (C2_NUM1_I == 8'h01) && (C2_DEN1_I == 8'h01)
      && (C2_NUM2_I == 8'h01) && (C2_DEN2_I == 8'h01) && (C2_OFS_I == 32'h0000_0000)
      |=> C2_OUT_O == awc_pkg::sat16($signed({48'h0000_0000_0000, $past(C2_IN1_I)})
                                   + $signed({48'h0000_0000_0000, $past(C2_IN2_I)}));
   endproperty
   a_c2_mode1_add: assert property (p_c2_mode1_add) else $error("calc2 mode 1 sum wrong");

   property p_c2_dword;
      c2_mode2 && (C2_NUM1_I == 8'h01) && (C2_DEN1_I == 8'h01) && (C2_OFS_I == 32'h0000_0000)
      |=> C2_OUT_O == (($past(C2_IN1_I) != 16'h0000) ? 16'hFFFF : $past(C2_IN2_I));
   endproperty
   a_c2_dword: assert property (p_c2_dword) else $error("calc2 double word order wrong");

   property p_c2_ofs;
      c2_mode2 && (C2_NUM1_I == 8'h00) && (C2_DEN1_I != 8'h00) && (C2_OFS_I == 32'h0000_1234)
      |=> C2_OUT_O == 16'h1234;
   endproperty
   a_c2_ofs: assert property (p_c2_ofs) else $error("calc2 mode 2 offset wrong");

   property p_c2_ignore;
      c2_mode2 && $stable(C2_IN1_I) && $stable(C2_IN2_I) && $stable(C2_NUM1_I) && $stable(C2_DEN1_I)
      && $stable(C2_OFS_I) && $past(c2_mode2) && $past(RST_B_I) ##1 1'b1 |-> $stable(C2_OUT_O);
   endproperty
   a_c2_ignore: assert property (p_c2_ignore) else $error("calc2 mode 2 used mode 1 parameters");

   property p_c3_prio;
      (C3_FIX_I == 4'h0) && (C3_OP_I == 6'h09) && (C3_PRIO1_I == 2'h2) && (C3_PRIO2_I == 2'h1)
      |=> C3_OUT_O == awc_pkg::sat16($signed({48'h0000_0000_0000, $past(C3_IN_I[15:0])})
          - $signed({48'h0000_0000_0000, $past(C3_IN_I[31:16])})
          * $signed({48'h0000_0000_0000, $past(C3_IN_I[47:32])})
          + $signed({48'h0000_0000_0000, $past(C3_IN_I[63:48])}));
   endproperty
   a_c3_prio: assert property (p_c3_prio) else $error("calc3 priority order wrong");

   property p_c4_fixed;
      (C4_FIX_I == 4'hF) && (C4_OP_I == 6'h00)
      |=> C4_OUT_O == awc_pkg::sat16($signed({48'h0000_0000_0000, $past(C4_CONST_I[15:0])})
          + $signed({48'h0000_0000_0000, $past(C4_CONST_I[31:16])})
          + $signed({48'h0000_0000_0000, $past(C4_CONST_I[47:32])})
          + $signed({48'h0000_0000_0000, $past(C4_CONST_I[63:48])}));
   endproperty
   a_c4_fixed: assert property (p_c4_fixed) else $error("calc4 fixed level not used");

   property p_c3_div0;
      (C3_FIX_I == 4'h0) && (C3_OP_I == 6'h03) && (C3_PRIO1_I == 2'h0) && (C3_IN_I[31:16] == 16'h0000)
      |=> C3_OUT_O == 16'hFFFF;
   endproperty
   a_c3_div0: assert property (p_c3_div0) else $error("calc3 divide by zero not 65535");

   // A zero denominator 1 forces full scale in every mode; a zero denominator 2 only outside mode 2
   property p_c2_den1_zero;
      (C2_DEN1_I == 8'h00) |=> C2_OUT_O == 16'hFFFF;
   endproperty
   a_c2_den1_zero: assert property (p_c2_den1_zero) else $error("calc2 zero denominator 1 not 65535");

   property p_c2_den2_zero;
      (C2_MODE_I != `AWC_MODE_DWORD) && (C2_DEN2_I == 8'h00)
      |=> C2_OUT_O == 16'hFFFF;
   endproperty
   a_c2_den2_zero: assert property (p_c2_den2_zero) else $error("calc2 zero denominator 2 not 65535");

   property p_c3_last_div;
      (C3_OP_I[5:4] == 2'h3) && ((C3_FIX_I[3] ? C3_CONST_I[63:48] : C3_IN_I[63:48]) == 16'h0000)
      |=> C3_OUT_O == 16'hFFFF;
   endproperty
   a_c3_last_div: assert property (p_c3_last_div) else $error("calc3 divide by zero input 4 not 65535");

   // Zero numerator leaves only a non-negative offset
   property p_c1_ofs_only;
      (C1_NUM_I == 16'h0000) && (C1_DEN_I != 8'h00) && !C1_OFS_I[15]
      |=> C1_OUT_O == $past(C1_OFS_I);
   endproperty
   a_c1_ofs_only: assert property (p_c1_ofs_only) else $error("calc1 offset alone wrong");

   property p_reset_clear;
      $rose(RST_B_I) |-> (C1_OUT_O == 16'h0000) && (C2_OUT_O == 16'h0000) && (C3_OUT_O == 16'h0000)
                         && (C4_OUT_O == 16'h0000);
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("outputs not cleared by reset");

   c_c2_mode2: cover property (c2_mode2 ##1 C2_OUT_O != 16'h0000);
   c_c3_right_first: cover property (!g_chain[0].u_chain.left_first ##1 C3_OUT_O != 16'h0000);
   c_c4_sat_high: cover property (C4_OUT_O == 16'hFFFF);
   c_c1_scaled: cover property ((C1_DEN_I > 8'h01) ##1 C1_OUT_O != 16'h0000);
   c_c2_mode1: cover property ((C2_MODE_I == 2'h1) ##1 C2_OUT_O != 16'hFFFF);

endmodule : awc_top

/* awc_top_tb.sv */
// Self-checking testbench for the analog word calculators
`timescale 1ns/1ns

module awc_top_tb;
   // ----------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------
   localparam awc_pkg::awc_wide_t ZERO = 64'sh0000_0000_0000_0000;
   localparam awc_pkg::awc_wide_t ONE = 64'sh0000_0000_0000_0001;
   localparam awc_pkg::awc_wide_t LIM = 64'sh0000_0000_8000_0000;
   localparam awc_pkg::awc_wide_t C1_MIN = -64'sh0000_0000_0000_7ffe;
   localparam logic [39:0] C1_TAB [4] = '{40'h8000_05_0000, 40'h0001_00_0000, 40'hffff_01_0000, 40'h7fff_ff_7fff};
   logic MCLK_I, RST_B_I = 1'b0;
   logic [15:0] C1_IN_I = 16'h0000, C1_NUM_I = 16'h0000, C1_OFS_I = 16'h0000;
   logic [7:0] C1_DEN_I = 8'h00, C2_NUM1_I = 8'h00, C2_DEN1_I = 8'h00, C2_NUM2_I = 8'h00, C2_DEN2_I = 8'h00;
   logic [15:0] C2_IN1_I = 16'h0000, C2_IN2_I = 16'h0000;
   logic [31:0] C2_OFS_I = 32'h0000_0000;
   logic [1:0] C2_MODE_I = 2'h0, C2_OP_I = 2'h0, C3_PRIO1_I = 2'h0, C3_PRIO2_I = 2'h0, C4_PRIO1_I = 2'h0;
   logic [1:0] C4_PRIO2_I = 2'h0;
   logic [63:0] C3_IN_I = 64'h0000_0000_0000_0000, C3_CONST_I = 64'h0000_0000_0000_0000;
   logic [63:0] C4_IN_I = 64'h0000_0000_0000_0000, C4_CONST_I = 64'h0000_0000_0000_0000;
   logic [3:0] C3_FIX_I = 4'h0, C4_FIX_I = 4'h0;
   logic [5:0] C3_OP_I = 6'h00, C4_OP_I = 6'h00;
   logic [15:0] C1_OUT_O, C2_OUT_O, C3_OUT_O, C4_OUT_O;
   logic [31:0] seed = 32'hf9ee;
   logic dz;
   int fail_count = 0;
   int checks = 0;
   int cyc = 0;

   awc_top awc_top_inst (
      .MCLK_I(MCLK_I), .RST_B_I(RST_B_I),
      .C1_IN_I(C1_IN_I), .C1_NUM_I(C1_NUM_I), .C1_DEN_I(C1_DEN_I), .C1_OFS_I(C1_OFS_I),
      .C2_IN1_I(C2_IN1_I), .C2_IN2_I(C2_IN2_I), .C2_NUM1_I(C2_NUM1_I), .C2_DEN1_I(C2_DEN1_I),
      .C2_NUM2_I(C2_NUM2_I), .C2_DEN2_I(C2_DEN2_I), .C2_OFS_I(C2_OFS_I), .C2_MODE_I(C2_MODE_I), .C2_OP_I(C2_OP_I),
      .C3_IN_I(C3_IN_I), .C3_FIX_I(C3_FIX_I), .C3_CONST_I(C3_CONST_I), .C3_OP_I(C3_OP_I),
      .C3_PRIO1_I(C3_PRIO1_I), .C3_PRIO2_I(C3_PRIO2_I),
      .C4_IN_I(C4_IN_I), .C4_FIX_I(C4_FIX_I), .C4_CONST_I(C4_CONST_I), .C4_OP_I(C4_OP_I),
      .C4_PRIO1_I(C4_PRIO1_I), .C4_PRIO2_I(C4_PRIO2_I),
      .C1_OUT_O(C1_OUT_O), .C2_OUT_O(C2_OUT_O), .C3_OUT_O(C3_OUT_O), .C4_OUT_O(C4_OUT_O)
   );

   initial begin
      MCLK_I = 1'b0;
      forever #5 MCLK_I = ~MCLK_I;
   end

   // ----------------------------------------
   // Reference arithmetic
   // ----------------------------------------
   function automatic logic [31:0] rnd();
      for (int i = 0; i < 32; i++) begin
         seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      end
      return seed;
   endfunction : rnd

   function automatic awc_pkg::awc_wide_t m_op(input awc_pkg::awc_wide_t a, input awc_pkg::awc_wide_t b,
                                              input logic [1:0] op);
      awc_pkg::awc_wide_t r;
      r = a;
      case (op)
         2'h0: r = a + b;
         2'h1: r = a - b;
         2'h2: r = a * b;
         default: begin
            if (b == ZERO) dz = 1'b1;
            else r = a / b;
         end
      endcase
      if (r > LIM) r = LIM;
      if (r < -LIM) r = -LIM;
      return r;
   endfunction : m_op

   function automatic logic [15:0] m_sat(input awc_pkg::awc_wide_t v);
      logic [15:0] r;
      r = v[15:0];
      if (dz || v > 64'sh0000_0000_0000_ffff) r = 16'hffff;
      else if (v < ZERO) r = 16'h0000;
      return r;
   endfunction : m_sat

   function automatic logic [15:0] exp_c1();
      awc_pkg::awc_wide_t a, n, d, o;
      a = C1_IN_I;
      n = $signed(C1_NUM_I);
      o = $signed(C1_OFS_I);
      d = C1_DEN_I;
      if (n < C1_MIN) n = C1_MIN;
      if (o < C1_MIN) o = C1_MIN;
      dz = (d == ZERO);
      if (dz) d = ONE;
      return m_sat(a * n / d + o);
   endfunction : exp_c1

   function automatic logic [15:0] exp_c2();
      awc_pkg::awc_wide_t a, b, n1, d1, n2, d2, o;
      a = {C2_IN1_I, C2_IN2_I};
      b = C2_IN2_I;
      n1 = $signed(C2_NUM1_I);
      d1 = C2_DEN1_I;
      n2 = C2_NUM2_I;
      d2 = $signed(C2_DEN2_I);
      o = $signed(C2_OFS_I);
      dz = (d1 == ZERO);
      if (dz) d1 = ONE;
      if (C2_MODE_I == 2'h2) return m_sat(a * n1 / d1 + o);
      if (d2 == ZERO) dz = 1'b1;
      if (d2 == ZERO) d2 = ONE;
      a = C2_IN1_I;
      a = m_op(a * n1 / d1, b * n2 / d2, C2_OP_I);
      return m_sat(a + o);
   endfunction : exp_c2

   function automatic logic [15:0] exp_chain(input logic [63:0] iv, input logic [3:0] fx, input logic [63:0] cv,
                                             input logic [5:0] op, input logic [1:0] p1, input logic [1:0] p2);
      awc_pkg::awc_wide_t w [4];
      awc_pkg::awc_wide_t t;
      for (int i = 0; i < 4; i++) begin
         w[i] = fx[i] ? cv[16*i +: 16] : iv[16*i +: 16];
      end
      dz = 1'b0;
      if (((p1 == 2'h0) ? 2'h0 : (p1 == 2'h1) ? 2'h1 : 2'h2) <= ((p2 >= 2'h2) ? 2'h2 : 2'h1)) begin
         t = m_op(w[0], w[1], op[1:0]);
         t = m_op(t, w[2], op[3:2]);
      end else begin
         t = m_op(w[1], w[2], op[3:2]);
         t = m_op(w[0], t, op[1:0]);
      end
      return m_sat(m_op(t, w[3], op[5:4]));
   endfunction : exp_chain

   // ----------------------------------------
   // Checking and drive tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic step();
      @(posedge MCLK_I);
      #1;
      chk("c1_out", exp_c1(), C1_OUT_O);
      chk("c2_out", exp_c2(), C2_OUT_O);
      chk("c3_out", exp_chain(C3_IN_I, C3_FIX_I, C3_CONST_I, C3_OP_I, C3_PRIO1_I, C3_PRIO2_I), C3_OUT_O);
      chk("c4_out", exp_chain(C4_IN_I, C4_FIX_I, C4_CONST_I, C4_OP_I, C4_PRIO1_I, C4_PRIO2_I), C4_OUT_O);
   endtask : step

   task automatic rnd_all();
      {C1_IN_I, C1_NUM_I} <= rnd();
      {C1_OFS_I, C1_DEN_I, C2_NUM1_I} <= rnd();
      {C2_IN1_I, C2_IN2_I} <= rnd();
      {C2_DEN1_I, C2_NUM2_I, C2_DEN2_I, C2_MODE_I, C2_OP_I} <= 28'(rnd());
      C2_OFS_I <= rnd();
      C3_IN_I <= {rnd(), rnd()};
      C4_IN_I <= {rnd(), rnd()};
      C3_CONST_I <= {rnd(), rnd()};
      C4_CONST_I <= {rnd(), rnd()};
      {C3_FIX_I, C4_FIX_I, C3_OP_I, C4_OP_I, C3_PRIO1_I, C3_PRIO2_I, C4_PRIO1_I, C4_PRIO2_I} <= 28'(rnd());
   endtask : rnd_all

   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_of_test

   always @(posedge MCLK_I) begin
      cyc++;
      if (cyc == 10000) begin
         fail_count++;
         end_of_test();
      end
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (16) @(posedge MCLK_I);
      #1;
      chk("reset_out", 16'h0000, C1_OUT_O | C2_OUT_O | C3_OUT_O | C4_OUT_O);
      @(posedge MCLK_I);
      RST_B_I <= 1'b1;
      {C1_IN_I, C1_NUM_I, C1_DEN_I, C1_OFS_I} <= 56'h000a_0003_02_0001;
      {C3_IN_I, C3_OP_I, C3_PRIO1_I, C3_PRIO2_I} <= {64'h0004_0003_0002_0001, 6'h09, 2'h2, 2'h1};
      step();
      chk("c1_walk", 16'h0010, C1_OUT_O);
      chk("c3_walk", 16'h0000, C3_OUT_O);
      for (int i = 0; i < 4; i++) begin
         @(posedge MCLK_I);
         {C1_NUM_I, C1_DEN_I, C1_OFS_I} <= C1_TAB[i];
         C1_IN_I <= 16'hffff;
         step();
      end
      for (int i = 0; i < 4; i++) begin
         @(posedge MCLK_I);
         {C2_IN1_I, C2_IN2_I, C2_NUM1_I, C2_DEN1_I, C2_OFS_I, C2_MODE_I} <= {48'h0001_0000_01_02, 32'h0, 2'h2};
         {C2_OP_I, C2_NUM2_I} <= {i[1:0], 8'(rnd())};
         C2_DEN2_I <= (i == 0) ? 8'h00 : 8'(rnd());
         step();
         chk("c2_dword", 16'h8000, C2_OUT_O);
      end
      @(posedge MCLK_I);
      {C2_IN1_I, C2_IN2_I, C2_NUM1_I, C2_DEN1_I, C2_OFS_I} <= {48'h0000_0001_80_01, 32'h0000_00ff};
      step();
      chk("c2_neg_num", 16'h007f, C2_OUT_O);
      for (int i = 0; i < 8; i++) begin
         @(posedge MCLK_I);
         {C2_MODE_I, C2_OP_I} <= i[3:0];
         C2_OFS_I <= i[0] ? 32'h7fff_ffff : 32'h8000_0000;
         step();
      end
      // Corner cases: unity scaling, plain mode 1 sum, zero divisor, offset alone
      @(posedge MCLK_I);
      {C1_IN_I, C1_NUM_I, C1_DEN_I, C1_OFS_I} <= 56'h1234_0001_01_0000;
      {C2_IN1_I, C2_IN2_I, C2_MODE_I, C2_OP_I} <= {32'h00ff_0100, 4'h4};
      {C2_NUM1_I, C2_DEN1_I, C2_NUM2_I, C2_DEN2_I, C2_OFS_I} <= {32'h0101_0101, 32'h0000_0000};
      {C3_IN_I, C3_OP_I, C3_PRIO1_I} <= {64'h0004_0003_0000_0001, 6'h03, 2'h0};
      step();
      chk("c1_unity", 16'h1234, C1_OUT_O);
      chk("c2_add", 16'h01ff, C2_OUT_O);
      chk("c3_div0", 16'hffff, C3_OUT_O);
      @(posedge MCLK_I);
      {C2_MODE_I, C2_NUM1_I, C2_OFS_I} <= {2'h2, 8'h00, 32'h0000_1234};
      step();
      chk("c2_ofs", 16'h1234, C2_OUT_O);
      for (int k = 0; k < 1024; k++) begin
         @(posedge MCLK_I);
         {C3_PRIO2_I, C3_PRIO1_I, C3_OP_I} <= k[9:0];
         {C4_PRIO2_I, C4_PRIO1_I, C4_OP_I} <= ~k[9:0];
         {C3_FIX_I, C4_FIX_I} <= {k[3:0], k[9:6]};
         {C3_IN_I, C4_IN_I} <= {64'h0002_0005_0003_0007, 64'h0009_0000_0004_0001};
         {C3_CONST_I, C4_CONST_I} <= {64'h0000_0001_0004_0006, 64'h0003_ffff_0002_0000};
         step();
      end
      for (int k = 0; k < 300; k++) begin
         @(posedge MCLK_I);
         rnd_all();
         if (k == 150) begin
            RST_B_I <= 1'b0;
            @(posedge MCLK_I);
            #1;
            chk("mid_reset_out", 16'h0000, C1_OUT_O | C2_OUT_O | C3_OUT_O | C4_OUT_O);
            @(posedge MCLK_I);
            RST_B_I <= 1'b1;
         end
         step();
      end
      end_of_test();
   end

endmodule : awc_top_tb
